// [verilog/pes_params.svh]
/*
  Named constants for the motion engine scan control block: register
  indexes, field positions, reset values and timing figures.
  Assumes it is included once each by the package and the testbench.
*/
`ifndef PES_PARAMS_SVH
`define PES_PARAMS_SVH

// Register indexes; the APB byte address is four times the index.
`define PES_IDX_SCAN_CFG   10'h103
`define PES_IDX_RANGE      10'h104
`define PES_IDX_AUX_REQ    10'h105
`define PES_IDX_CONV_CTRL  10'h106
`define PES_IDX_STATUS     10'h107
`define PES_IDX_AUX_RESULT 10'h10A
`define PES_IDX_VERSION    10'h10C

// Scan configuration and range fields.
`define PES_FREQ_MSB       6
`define PES_FREQ_LSB       3
`define PES_FREQ_MAX       4'hC
`define PES_SCAN_RATE_BIT  2
`define PES_DUAL_BIT       0
`define PES_SCAN_CFG_RST   8'h00
`define PES_RANGE_MASK     8'h07
`define PES_RANGE_RST      8'h00
// Writable request bits; bits 3 and 2 are reserved.
`define PES_AUX_REQ_MASK   8'hF3
`define PES_CONV_START_BIT 7
`define PES_MOTION_BIT     1
`define PES_SUPPRESS_BIT   0

// Sensor channels and timing.
`define PES_CH_FIRST       3'h2
`define PES_CH_SECOND      3'h3
`define PES_NORMAL_CYCLES  256
`define PES_LOW_CYCLES     5129
`define PES_CLOCK_KHZ      25000
`define PES_SUPPRESS_MS    200

`endif

// [verilog/pes_pkg.sv]
/*
  Types shared by the motion engine scan control block.
  Assumes pes_params.svh is found on the include path.
*/
package pes_pkg;
  `include "pes_params.svh"

  // Converter sequencer states.
  typedef enum logic [1:0] {
    PES_IDLE,
    PES_CONVERT
  } pes_state_t;

  // Who owns the conversion in progress.
  typedef enum logic {
    PES_JOB_SENSOR,
    PES_JOB_AUX
  } pes_job_t;
endpackage

// [verilog/pes_scan_control.sv]
/*
  Scan control of the infrared motion engine: APB register file, the
  converter sequencer for sensor and auxiliary scans, motion flag and
  the settling hold after a scan-rate change.
  Assumes the converter and the motion detector run on i_clock, so
  their signals need no synchroniser, and an APB master on i_clock.
*/
`timescale 1ns/1ps

module pes_scan_control
  import pes_pkg::*;
#(
  parameter int         SUPPRESS_CYCLES = `PES_SUPPRESS_MS * `PES_CLOCK_KHZ,
  parameter logic [7:0] VERSION_CODE    = 8'h5A  // Arbitrary value.
) (
  // Clock and reset.
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  // APB slave.
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic [31:0]      o_prdata,
  // Converter.
  input  wire logic [15:0] i_adc_data,
  output logic             o_adc_power,
  output logic             o_adc_continuous,
  output logic             o_adc_start,
  output logic [2:0]       o_adc_channel,
  output logic             o_adc_dual,
  output logic             o_adc_ref_2v,
  output logic [7:0]       o_pin_analog,
  output logic             o_conv_event,
  // Detection engine.
  input  wire logic        i_motion_first,
  input  wire logic        i_motion_second,
  output logic [3:0]       o_freq_response,
  output logic [2:0]       o_range,
  output logic             o_emi_enable,
  output logic             o_detect_enable,
  output logic             o_motion_detected
);

  localparam int SUP_W = $clog2(SUPPRESS_CYCLES + 1);
  localparam logic [12:0] NORMAL_LAST = 13'(`PES_NORMAL_CYCLES - 1);
  localparam logic [12:0] LOW_LAST    = 13'(`PES_LOW_CYCLES - 1);
  localparam logic [SUP_W-1:0] SUP_LOAD = SUP_W'(SUPPRESS_CYCLES);

  // Lowest set request bit as a channel number.
  function automatic logic [2:0] lowest_channel(input logic [7:0] req);
    logic [2:0] ch;
    ch = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (req[i]) begin
        ch = 3'(i);
      end
    end
    return ch;
  endfunction

  // Register state.
  logic [7:0]       scan_cfg;
  logic [7:0]       range;
  logic [7:0]       aux_req;
  logic [15:0]      aux_result;
  logic             motion;
  logic             conv_start;
  logic             pready;
  logic             pslverr;
  logic [31:0]      prdata;
  logic [7:0]       next_scan_cfg;
  logic [7:0]       next_range;
  logic [7:0]       next_aux_req;
  logic [15:0]      next_aux_result;
  logic             next_motion;
  logic             next_conv_start;
  logic             next_pready;
  logic             next_pslverr;
  logic [31:0]      next_prdata;
  // Sequencer state.
  pes_state_t       state;
  pes_state_t       next_state;
  pes_job_t         job;
  pes_job_t         next_job;
  logic [12:0]      count;
  logic [12:0]      next_count;
  logic [2:0]       channel;
  logic [2:0]       next_channel;
  logic [7:0]       pin_analog;
  logic [7:0]       next_pin_analog;
  logic             start;
  logic             next_start;
  logic             event_q;
  logic             next_event;
  logic [SUP_W-1:0] hold;
  logic [SUP_W-1:0] next_hold;

  logic       access;
  logic       wr;
  logic [9:0] idx;
  logic       low_rate;
  logic       conv_done;
  logic [3:0] freq_w;

  assign access    = i_psel & i_penable;
  assign wr        = access & pready & i_pwrite;
  assign idx       = i_paddr[11:2];
  assign low_rate  = scan_cfg[`PES_SCAN_RATE_BIT];
  assign conv_done = (state == PES_CONVERT) && (count == 13'h0);
  assign freq_w    = i_pwdata[`PES_FREQ_MSB:`PES_FREQ_LSB];

  // Bus answer is registered: pready rises one cycle into the access.
  always_comb begin
    next_pready  = access & ~pready;
    next_pslverr = 1'b0;
    next_prdata  = prdata;
    if (access && !pready) begin
      next_prdata = 32'h0000_0000;
      case (idx)
        `PES_IDX_SCAN_CFG:   next_prdata[7:0] = scan_cfg;
        `PES_IDX_RANGE:      next_prdata[7:0] = range;
        `PES_IDX_AUX_REQ:    next_prdata[7:0] = aux_req;
        `PES_IDX_CONV_CTRL:  next_prdata[`PES_CONV_START_BIT] = conv_start;
        `PES_IDX_STATUS: begin
          next_prdata[`PES_MOTION_BIT]   = motion;
          next_prdata[`PES_SUPPRESS_BIT] = hold != '0;
        end
        `PES_IDX_AUX_RESULT: next_prdata[15:0] = aux_result;
        `PES_IDX_VERSION:    next_prdata[7:0] = VERSION_CODE;
        default:             next_pslverr = 1'b1;
      endcase
    end
  end

  // Software-facing registers; hardware sets win over software clears.
  always_comb begin
    next_scan_cfg   = scan_cfg;
    next_range      = range;
    next_aux_req    = aux_req;
    next_aux_result = aux_result;
    next_motion     = motion;
    next_conv_start = conv_start;
    if (wr) begin
      case (idx)
        `PES_IDX_SCAN_CFG: begin
          next_scan_cfg = 8'h00;
          // Settings above the top code clamp to the top code.
          next_scan_cfg[`PES_FREQ_MSB:`PES_FREQ_LSB] =
            (freq_w > `PES_FREQ_MAX) ? `PES_FREQ_MAX : freq_w;
          next_scan_cfg[`PES_SCAN_RATE_BIT] =
            i_pwdata[`PES_SCAN_RATE_BIT];
          next_scan_cfg[`PES_DUAL_BIT] = i_pwdata[`PES_DUAL_BIT];
        end
        `PES_IDX_RANGE:
          next_range = i_pwdata[7:0] & `PES_RANGE_MASK;
        `PES_IDX_AUX_REQ:
          next_aux_req = i_pwdata[7:0] & `PES_AUX_REQ_MASK;
        `PES_IDX_CONV_CTRL:
          next_conv_start = conv_start | i_pwdata[`PES_CONV_START_BIT];
        `PES_IDX_STATUS:
          if (i_pwdata[`PES_MOTION_BIT]) begin
            next_motion = 1'b0;
          end
        default: ;
      endcase
    end
    // A finished aux job stores its sample and drops every request,
    // unless software writes a fresh request in that very cycle.
    if (conv_done && job == PES_JOB_AUX) begin
      next_aux_result = i_adc_data;
      if (!(wr && idx == `PES_IDX_AUX_REQ)) begin
        next_aux_req = 8'h00;
      end
    end
    // The start bit is consumed whenever the idle sequencer sees it at low rate,
    // even when aux work takes that slot. A fresh start written in that same
    // cycle stays pending for the next shot.
    if (state == PES_IDLE && low_rate && conv_start) begin
      next_conv_start = wr && idx == `PES_IDX_CONV_CTRL &&
                        i_pwdata[`PES_CONV_START_BIT];
    end
    // Either sensor may flag motion in dual mode; set beats clear.
    if ((i_motion_first | (scan_cfg[`PES_DUAL_BIT] & i_motion_second))
        && hold == '0) begin
      next_motion = 1'b1;
    end
  end

  // Converter sequencer. Normal rate runs back to back; low rate waits
  // for the start bit and powers down between shots.
  always_comb begin
    next_state      = state;
    next_job        = job;
    next_count      = count;
    next_channel    = channel;
    next_pin_analog = pin_analog;
    next_start      = 1'b0;
    next_event      = 1'b0;
    if (state == PES_CONVERT && count != 13'h0) begin
      next_count = count - 13'h1;
    end
    if (conv_done) begin
      next_event = job == PES_JOB_SENSOR;
      next_state = PES_IDLE;
    end
    if ((state == PES_IDLE || conv_done) &&
        (!low_rate || conv_start || aux_req != 8'h00)) begin
      next_state = PES_CONVERT;
      next_start = 1'b1;
      next_count = low_rate ? LOW_LAST : NORMAL_LAST;
      // Aux work takes the slot; at normal rate the sensor waits its turn.
      if (aux_req != 8'h00 && !(conv_done && job == PES_JOB_AUX)) begin
        next_job     = PES_JOB_AUX;
        next_channel = lowest_channel(aux_req);
        next_pin_analog[lowest_channel(aux_req)] = 1'b1;
      end else if (!low_rate || conv_start) begin
        next_job     = PES_JOB_SENSOR;
        next_channel = `PES_CH_FIRST;
      end else begin
        next_state = PES_IDLE;
        next_start = 1'b0;
      end
    end
  end

  // Detection hold after a scan-rate change; the filter settles slowly.
  always_comb begin
    next_hold = hold;
    if (hold != '0) begin
      next_hold = hold - SUP_W'(1);
    end
    if (wr && idx == `PES_IDX_SCAN_CFG &&
        i_pwdata[`PES_SCAN_RATE_BIT] != low_rate) begin
      next_hold = SUP_LOAD;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= 32'h0000_0000;
      scan_cfg   <= `PES_SCAN_CFG_RST;
      range      <= `PES_RANGE_RST;
      aux_req    <= 8'h00;
      aux_result <= 16'h0000;
      motion     <= 1'b0;
      conv_start <= 1'b0;
      state      <= PES_IDLE;
      job        <= PES_JOB_SENSOR;
      count      <= 13'h0;
      channel    <= `PES_CH_FIRST;
      pin_analog <= 8'h00;
      start      <= 1'b0;
      event_q    <= 1'b0;
      hold       <= '0;
    end else begin
      pready     <= next_pready;
      pslverr    <= next_pslverr;
      prdata     <= next_prdata;
      scan_cfg   <= next_scan_cfg;
      range      <= next_range;
      aux_req    <= next_aux_req;
      aux_result <= next_aux_result;
      motion     <= next_motion;
      conv_start <= next_conv_start;
      state      <= next_state;
      job        <= next_job;
      count      <= next_count;
      channel    <= next_channel;
      pin_analog <= next_pin_analog;
      start      <= next_start;
      event_q    <= next_event;
      hold       <= next_hold;
    end
  end

  // Derived outputs, all from flip-flops.
  always_comb begin
    o_pready          = pready;
    o_pslverr         = pslverr;
    o_prdata          = prdata;
    o_adc_power       = state == PES_CONVERT;
    o_adc_continuous  = ~low_rate;
    o_adc_start       = start;
    o_adc_channel     = channel;
    o_adc_dual        = scan_cfg[`PES_DUAL_BIT] && job == PES_JOB_SENSOR;
    o_adc_ref_2v      = job == PES_JOB_AUX;
    o_pin_analog      = pin_analog;
    o_conv_event      = event_q;
    o_freq_response   = scan_cfg[`PES_FREQ_MSB:`PES_FREQ_LSB];
    o_range           = range[2:0];
    o_emi_enable      = ~low_rate;
    o_detect_enable   = hold == '0;
    o_motion_detected = motion;
  end

  // Assertion helper: clocks since the last start and the rate that the
  // conversion began at. Long repetitions would choke the tools.
  logic [12:0] gap;
  logic [12:0] next_gap;
  logic        start_rate;
  logic        next_start_rate;

  // The gap saturates, so a long idle stretch cannot wrap it.
  always_comb begin
    next_gap        = gap;
    next_start_rate = start_rate;
    if (start) begin
      next_gap = 13'h1;
    end else if (gap != '1) begin
      next_gap = gap + 13'h1;
    end
    if (next_start) begin
      next_start_rate = low_rate;
    end
  end

  // Helper registers for the length checks.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      gap        <= 13'h0;
      start_rate <= 1'b0;
    end else begin
      gap        <= next_gap;
      start_rate <= next_start_rate;
    end
  end

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  a_freq_clamp: assert property (
    scan_cfg[`PES_FREQ_MSB:`PES_FREQ_LSB] <= `PES_FREQ_MAX)
    else $error("frequency field above top code");
  a_normal_period: assert property (
    (conv_done && !start_rate) |-> gap == NORMAL_LAST)
    else $error("normal conversion not 256 clocks");
  a_low_length: assert property (
    (conv_done && start_rate) |-> gap == LOW_LAST)
    else $error("low rate conversion not 5129 clocks");
  a_low_power_off: assert property (
    (low_rate && state == PES_IDLE) |-> !o_adc_power)
    else $error("converter powered between shots");
  a_emi_off: assert property (
    $rose(low_rate) |-> ##1 !o_emi_enable)
    else $error("immunity left on at low rate");
  a_hold_rate: assert property (
    (wr && idx == `PES_IDX_SCAN_CFG &&
     i_pwdata[`PES_SCAN_RATE_BIT] != low_rate) |=> !o_detect_enable)
    else $error("detection not held after rate change");
  a_dual_motion: assert property (
    (scan_cfg[`PES_DUAL_BIT] && i_motion_second && hold == '0)
      |=> motion)
    else $error("second sensor motion lost");
  a_aux_clear: assert property (
    (conv_done && job == PES_JOB_AUX && !wr) |=>
      aux_req == 8'h00 && aux_result == $past(i_adc_data))
    else $error("aux completion not stored");
  a_aux_lowest: assert property (
    (start && job == PES_JOB_AUX) |->
      channel == lowest_channel(aux_req))
    else $error("aux channel not lowest request");
  a_result_stable: assert property (
    !(($past(conv_done) && $past(job) == PES_JOB_AUX))
      |-> $stable(aux_result))
    else $error("result changed without aux completion");

  c_aux_done: cover property (conv_done && job == PES_JOB_AUX);
  c_low_shot: cover property (conv_done && low_rate);
  c_motion:   cover property ($rose(motion));
  c_hold:     cover property ($fell(o_detect_enable));

endmodule

// [verif/pes_conv_model.sv]
/*
  Converter and sensor model for the scan control bench.
  Assumes the bench commands the motion hits of both sensors.
*/
`timescale 1ns/1ps
module pes_conv_model (
  // Clock and reset.
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  // From the scan control block.
  input  wire logic        i_adc_power,
  input  wire logic [2:0]  i_adc_channel,
  // Motion commands from the bench.
  input  wire logic        i_hit_first,
  input  wire logic        i_hit_second,
  // Towards the scan control block.
  output logic [15:0]      o_adc_data,
  output logic             o_motion_first,
  output logic             o_motion_second
);
  logic [15:0] churn;

  // An unpowered converter holds no result, so the line keeps changing.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      churn <= 16'h0000;
    end else begin
      churn <= churn + 16'h3C5B;
    end
  end

  // The result carries its channel, so a wrong channel shows in the data.
  assign o_adc_data      = i_adc_power ? {13'h14A0, i_adc_channel} : churn;
  assign o_motion_first  = i_hit_first;
  assign o_motion_second = i_hit_second;
endmodule

// [verif/test_pir_engine_scan_control.sv]
/*
  Self-checking bench for the motion engine scan control block.
  Assumes pes_conv_model stands in for the converter and sensors.
*/
`timescale 1ns/1ps
`include "pes_params.svh"
module test_pir_engine_scan_control;
  import pes_pkg::*;
  localparam int HOLD = 50;  // A short hold keeps the run brief.
  logic        clk, resetn, psel, penable, pwrite, hit1, hit2, pready;
  logic        pslverr, power, cont, start, dual, ref2v, cevt, emi, det;
  logic        motion, mot1, mot2, err;
  logic [2:0]  chan, rng;
  logic [3:0]  freq;
  logic [7:0]  pin_an;
  logic [11:0] paddr;
  logic [15:0] adc;
  logic [31:0] pwdata, prdata, rd;
  int          fails, n_compared;

  // Clock at 25 MHz.
  always #20 clk = ~clk;

  // Design and its far-side model.
  pes_scan_control #(.SUPPRESS_CYCLES(HOLD)) dut_u (
    .i_clock(clk), .i_resetn(resetn), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_prdata(prdata), .i_adc_data(adc), .o_adc_power(power),
    .o_adc_continuous(cont), .o_adc_start(start), .o_adc_channel(chan),
    .o_adc_dual(dual), .o_adc_ref_2v(ref2v), .o_pin_analog(pin_an),
    .o_conv_event(cevt), .i_motion_first(mot1), .i_motion_second(mot2),
    .o_freq_response(freq), .o_range(rng), .o_emi_enable(emi),
    .o_detect_enable(det), .o_motion_detected(motion));
  pes_conv_model model_u (
    .i_clock(clk), .i_resetn(resetn), .i_adc_power(power),
    .i_adc_channel(chan), .i_hit_first(hit1), .i_hit_second(hit2),
    .o_adc_data(adc), .o_motion_first(mot1), .o_motion_second(mot2));

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("Compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Compares one value and logs a mismatch.
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // A wait that ran out counts as a mismatch and closes the run.
  task automatic give_up(input string what);
    fails++;
    $display("CHECK FAILED %s expected done seen timeout", what);
    final_report();
  endtask

  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic wr, input logic [9:0] idx,
                     input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) give_up("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Reads a register and compares the word.
  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp,
                        input string what);
    apb(1'b0, idx, 32'h0);
    check(what, exp, rd);
  endtask

  // Waits for a conversion start and returns the edges it took.
  task automatic wait_start(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (start !== 1'b1 && n < 600);
    if (start !== 1'b1) give_up("adc start");
  endtask

  // One-cycle motion hit on the chosen sensor.
  task automatic pulse(input logic second);
    if (second) hit2 <= 1'b1;
    else hit1 <= 1'b1;
    @(posedge clk);
    hit1 <= 1'b0;
    hit2 <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // Reset values, read-only version and an unmapped index.
  task automatic t_reset();
    check("emi", 1'b1, emi);
    rd_chk(`PES_IDX_SCAN_CFG, 32'h0, "scan cfg");
    apb(1'b1, `PES_IDX_VERSION, 32'hFF);
    rd_chk(`PES_IDX_VERSION, 32'h5A, "version");
    apb(1'b0, 10'h3FF, 32'h0);
    check("slverr", 1'b1, err);
    check("unmapped", 32'h0, rd);
  endtask

  // Field widths, clamping and reserved bits.
  task automatic t_config();
    for (int v = 0; v <= 12; v++) begin
      apb(1'b1, `PES_IDX_SCAN_CFG, 32'(v) << 3);
      check("freq out", 32'(v), freq);
    end
    apb(1'b1, `PES_IDX_SCAN_CFG, 32'hFFFF_FFFA);
    rd_chk(`PES_IDX_SCAN_CFG, 32'h60, "freq clamp");
    apb(1'b1, `PES_IDX_RANGE, 32'hFFFF_FFFF);
    rd_chk(`PES_IDX_RANGE, 32'h7, "range");
    check("range out", 3'h7, rng);
  endtask

  // Continuous rate: one start and one event every 256 clocks.
  task automatic t_normal();
    int n;
    int ev;
    ev = 0;
    wait_start(n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (cevt === 1'b1) ev++;
    end while (start !== 1'b1 && n < 600);
    check("period", 256, n);
    check("events", 1, ev);
    check("first ch", 3'h2, chan);
  endtask

  // Several requests: only the lowest channel converts, then all clear.
  task automatic t_aux();
    int n;
    apb(1'b1, `PES_IDX_AUX_REQ, 32'h1E);
    rd_chk(`PES_IDX_AUX_REQ, 32'h12, "pending");
    n = 0;
    while (ref2v !== 1'b1 && n < 600) begin
      @(posedge clk);
      n++;
    end
    if (ref2v !== 1'b1) give_up("aux scan");
    check("aux ch", 3'h1, chan);
    check("pin analog", 8'h02, pin_an);
    n = 0;
    do begin
      apb(1'b0, `PES_IDX_AUX_REQ, 32'h0);
      n++;
    end while (rd !== 32'h0 && n < 200);
    check("cleared", 32'h0, rd);
    rd_chk(`PES_IDX_AUX_RESULT, 32'hA501, "result");
    check("pin kept", 8'h02, pin_an);
  endtask

  // Second sensor counts only in dual mode; the flag holds until cleared.
  task automatic t_motion();
    apb(1'b1, `PES_IDX_SCAN_CFG, 32'h0);
    pulse(1'b1);
    check("single", 1'b0, motion);
    pulse(1'b0);
    check("first hit", 1'b1, motion);
    apb(1'b1, `PES_IDX_STATUS, 32'h2);
    apb(1'b1, `PES_IDX_SCAN_CFG, 32'h1);
    check("dual out", 1'b1, dual);
    pulse(1'b1);
    check("dual hit", 1'b1, motion);
    rd_chk(`PES_IDX_STATUS, 32'h2, "status");
    apb(1'b1, `PES_IDX_STATUS, 32'h2);
    check("flag clear", 1'b0, motion);
  endtask

  // Low rate: hold after the change, idle converter, one long shot.
  task automatic t_low();
    int n;
    // Tuning registers sit outside this block and count as loaded here.
    apb(1'b1, `PES_IDX_SCAN_CFG, 32'h4);
    check("continuous", 1'b0, cont);
    check("emi off", 1'b0, emi);
    check("detect", 1'b0, det);
    n = 0;
    while (det !== 1'b1 && n < 2 * HOLD) begin
      @(posedge clk);
      n++;
    end
    check("hold ends", 1'b1, det);
    n = 0;
    repeat (300) begin
      @(posedge clk);
      if (start === 1'b1) n++;
    end
    check("no shot", 0, n);
    check("power off", 1'b0, power);
    apb(1'b1, `PES_IDX_CONV_CTRL, 32'h80);
    wait_start(n);
    n = 0;
    while (power === 1'b1 && n < 6000) begin
      n++;
      @(posedge clk);
    end
    check("shot", 5129, n);
    rd_chk(`PES_IDX_CONV_CTRL, 32'h0, "start bit");
    rd_chk(`PES_IDX_AUX_RESULT, 32'hA501, "result kept");
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    hit1 = 1'b0;
    hit2 = 1'b0;
    fails = 0;
    n_compared = 0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_config();
    t_normal();
    t_aux();
    t_motion();
    t_low();
    final_report();
  end
endmodule
